// [bench/dbe_doorbell_ctrl_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module dbe_doorbell_ctrl_tb;
   logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, serr, mute;
   logic db_tx_valid, db_tx_ready, db_rsp_valid, db_irq, err_irq, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] db_rsp_code, code;
   logic [3:0] lag;
   int miscompares = 0;
   int n_compared = 0;
   // Clock of 25 ns
   always #12.5 mclk = ~mclk;
   dbe_doorbell_ctrl u_dbe_doorbell_ctrl (.mclk(mclk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .db_tx_valid(db_tx_valid),
      .db_tx_ready(db_tx_ready), .db_rsp_valid(db_rsp_valid), .db_rsp_code(db_rsp_code),
      .db_irq(db_irq), .err_irq(err_irq), .irq(irq));
   dbe_link_partner u_dbe_link_partner (.mclk(mclk), .reset_n(reset_n),
      .db_tx_valid(db_tx_valid), .code(code), .mute(mute), .lag(lag),
      .db_tx_ready(db_tx_ready), .db_rsp_valid(db_rsp_valid), .db_rsp_code(db_rsp_code));
   // Verdict and end of run
   task automatic close_out();
      if (miscompares == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One APB transfer, released after pready is seen at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge mclk);
      if (i == 20) begin
         miscompares++;
         close_out();
      end
      rd = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   // Output level checked once the edge has settled
   task automatic flag(ref logic got, input logic exp);
      @(negedge mclk);
      chk({31'h0, got}, {31'h0, exp});
   endtask
   task automatic wait_idle();
      int j;
      for (j = 0; j < 300; j++) begin
         apb(1'b0, dbe_pkg::STATUS_OFS, 32'h0);
         if (rd[dbe_pkg::ST_BUSY_BIT] === 1'b0) break;
      end
      if (j == 300) begin
         miscompares++;
         close_out();
      end
   endtask
   // Main sequence
   initial begin
      mclk = 1'b0;
      reset_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      code = dbe_pkg::RSP_DONE;
      mute = 1'b0;
      lag = 4'h0;
      repeat (3) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (3) @(posedge mclk);
      rc(dbe_pkg::ATTR_OFS, 32'h300);
      rc(dbe_pkg::STATUS_OFS, 32'h0);
      rc(8'h40, 32'h0);
      chk({31'h0, serr}, 32'h1);
      wr(dbe_pkg::DQ_PTR_OFS, 32'h40);
      wr(dbe_pkg::DQ_PTR_UPPER_OFS, 32'h1);
      wr(dbe_pkg::EQ_PTR_OFS, 32'h40);
      wr(dbe_pkg::EQ_PTR_UPPER_OFS, 32'h1);
      rc(dbe_pkg::DQ_PTR_OFS, 32'h40);
      rc(dbe_pkg::DQ_PTR_UPPER_OFS, 32'h1);
      rc(dbe_pkg::EQ_PTR_OFS, 32'h40);
      rc(dbe_pkg::EQ_PTR_UPPER_OFS, 32'h1);
      wr(dbe_pkg::ATTR_OFS, 32'h301);
      wr(dbe_pkg::IRQ_MASK_OFS, 32'h3);
      rc(dbe_pkg::IRQ_MASK_OFS, 32'h3);
      wr(dbe_pkg::ERR_ENABLE_OFS, 32'he);
      rc(dbe_pkg::ERR_ENABLE_OFS, 32'he);
      wr(dbe_pkg::MODE_OFS, 32'h3);
      wait_idle();
      rc(dbe_pkg::STATUS_OFS, 32'h1);
      rc(dbe_pkg::IRQ_STATUS_OFS, 32'h1);
      flag(irq, 1'b1);
      wr(dbe_pkg::STATUS_OFS, 32'h0);
      flag(db_irq, 1'b1);
      wr(dbe_pkg::STATUS_OFS, 32'h1);
      flag(db_irq, 1'b0);
      wr(dbe_pkg::IRQ_MASK_OFS, 32'h0);
      flag(irq, 1'b0);
      wr(dbe_pkg::IRQ_STATUS_OFS, 32'h3);
      wr(dbe_pkg::IRQ_MASK_OFS, 32'h3);
      flag(irq, 1'b0);
      // Error response, slow partner
      code <= dbe_pkg::RSP_ERROR;
      lag <= 4'h5;
      wr(dbe_pkg::MODE_OFS, 32'h3);
      wait_idle();
      rc(dbe_pkg::STATUS_OFS, 32'h3);
      rc(dbe_pkg::ERR_CAPTURE_OFS, 32'h8000_0002);
      flag(err_irq, 1'b1);
      wr(dbe_pkg::MODE_OFS, 32'h3);
      rc(dbe_pkg::MODE_OFS, 32'h1);
      rc(dbe_pkg::STATUS_OFS, 32'h3);
      flag(db_tx_valid, 1'b0);
      wr(dbe_pkg::MODE_OFS, 32'h0);
      rc(dbe_pkg::MODE_OFS, 32'h0);
      wr(dbe_pkg::STATUS_OFS, 32'h3);
      flag(err_irq, 1'b0);
      // Silent partner gives a timeout, capture keeps the first error
      wr(dbe_pkg::ERR_ENABLE_OFS, 32'h2);
      mute <= 1'b1;
      wr(dbe_pkg::MODE_OFS, 32'h3);
      rc(dbe_pkg::STATUS_OFS, 32'h10);
      wait_idle();
      flag(err_irq, 1'b0);
      wr(dbe_pkg::ERR_ENABLE_OFS, 32'h6);
      flag(err_irq, 1'b1);
      rc(dbe_pkg::STATUS_OFS, 32'h5);
      rc(dbe_pkg::ERR_CAPTURE_OFS, 32'h8000_0002);
      rc(dbe_pkg::STATUS_OFS, 32'h5);
      rc(dbe_pkg::PORTWRITE_OFS, 32'h1);
      wr(dbe_pkg::STATUS_OFS, 32'h0);
      rc(dbe_pkg::STATUS_OFS, 32'h5);
      wr(dbe_pkg::STATUS_OFS, 32'h4);
      rc(dbe_pkg::STATUS_OFS, 32'h1);
      flag(err_irq, 1'b0);
      wr(dbe_pkg::ERR_CAPTURE_OFS, 32'he);
      rc(dbe_pkg::ERR_CAPTURE_OFS, 32'h0);
      wr(dbe_pkg::PORTWRITE_OFS, 32'h1);
      rc(dbe_pkg::PORTWRITE_OFS, 32'h0);
      // Retries past the limit with the error interrupt off
      wr(dbe_pkg::MODE_OFS, 32'h0);
      wr(dbe_pkg::ERR_ENABLE_OFS, 32'h0);
      wr(dbe_pkg::STATUS_OFS, 32'h1);
      code <= dbe_pkg::RSP_RETRY;
      mute <= 1'b0;
      lag <= 4'h0;
      wr(dbe_pkg::MODE_OFS, 32'h3);
      wait_idle();
      rc(dbe_pkg::STATUS_OFS, 32'h9);
      flag(err_irq, 1'b0);
      rc(dbe_pkg::ERR_CAPTURE_OFS, 32'h8000_0008);
      wr(dbe_pkg::ERR_ENABLE_OFS, 32'h8);
      flag(err_irq, 1'b1);
      close_out();
   end
endmodule
`default_nettype wire

// [bench/dbe_doorbell_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module dbe_doorbell_props (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic db_tx_valid,
   input wire logic db_tx_ready,
   input wire logic db_rsp_valid,
   input wire logic db_irq,
   input wire logic err_irq,
   input wire logic irq
);
   // Write that takes effect at this edge
   wire logic wr_done = psel && penable && pready && pwrite;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   pready_late_a: assert property (psel && penable && !pready |=> pready)
      else $error("pready missing");
   pready_pulse_a: assert property (pready |=> !pready)
      else $error("pready too long");
   slverr_pair_a: assert property (pslverr |-> pready)
      else $error("pslverr alone");
   prdata_idle_a: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata not zero");
   tx_hold_a: assert property (db_tx_valid && !db_tx_ready |=> db_tx_valid)
      else $error("request dropped");
   tx_accept_a: assert property (db_tx_valid && db_tx_ready |=> !db_tx_valid)
      else $error("request kept");
   tx_start_a: assert property ($rose(db_tx_valid) |->
      $past(wr_done) || $past(db_rsp_valid))
      else $error("request without cause");
   db_irq_hold_a: assert property (db_irq && !(psel && penable && pwrite) |=> db_irq)
      else $error("db_irq dropped");
   err_irq_hold_a: assert property (err_irq && !wr_done |=> err_irq)
      else $error("err_irq dropped");
   irq_fall_a: assert property ($fell(irq) |-> $past(wr_done))
      else $error("irq fell alone");
   done_c: cover property ($rose(db_irq));
   err_c: cover property ($rose(err_irq));
   refuse_c: cover property (pslverr);
endmodule
bind dbe_doorbell_ctrl dbe_doorbell_props u_dbe_doorbell_props (
   .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pready(pready), .prdata(prdata), .pslverr(pslverr), .db_tx_valid(db_tx_valid),
   .db_tx_ready(db_tx_ready), .db_rsp_valid(db_rsp_valid), .db_irq(db_irq),
   .err_irq(err_irq), .irq(irq)
);
`default_nettype wire

// [bench/dbe_link_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module dbe_link_partner (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic db_tx_valid,
   input wire logic [1:0] code,
   input wire logic mute,
   input wire logic [3:0] lag,
   output logic db_tx_ready,
   output logic db_rsp_valid,
   output logic [1:0] db_rsp_code
);
   logic [3:0] cnt;
   logic busy;
   // Accept after lag cycles, answer after lag more unless muted
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cnt <= 4'h0;
         busy <= 1'b0;
         db_tx_ready <= 1'b0;
         db_rsp_valid <= 1'b0;
         db_rsp_code <= 2'h3;
      end else begin
         db_tx_ready <= 1'b0;
         db_rsp_valid <= 1'b0;
         db_rsp_code <= ~db_rsp_code; // Idle code keeps moving
         cnt <= (db_tx_valid || busy) ? cnt + 4'h1 : 4'h0;
         if (db_tx_valid && !db_tx_ready && !busy && cnt >= lag) begin
            db_tx_ready <= 1'b1;
            busy <= 1'b1;
            cnt <= 4'h0;
         end
         if (busy && cnt >= lag) begin
            busy <= 1'b0;
            db_rsp_valid <= !mute;
            db_rsp_code <= code;
         end
      end
   end
endmodule
`default_nettype wire

// [core/dbe_doorbell_ctrl.sv]
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none

module dbe_doorbell_ctrl (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   output logic db_tx_valid,
   input wire logic db_tx_ready,
   input wire logic db_rsp_valid,
   input wire logic [1:0] db_rsp_code,
   output logic db_irq,
   output logic err_irq,
   output logic irq
);

   logic [1:0] rst_sync;
   logic rst_n;
   dbe_pkg::dbe_regs_t r;
   dbe_pkg::dbe_regs_t next_r;

   // Bus decode
   logic acc;
   logic wr;
   // Sticky flag bank connections
   logic [3:0] st_set;
   logic [3:0] st_clr;
   logic [3:0] st_flags;
   logic pw_set;
   logic pw_clr;
   logic pw_flag;
   logic [1:0] irq_set;
   logic [1:0] irq_clr;
   logic [1:0] irq_flags;
   // Engine events and capture clears
   logic ev_done;
   logic ev_err_rsp;
   logic ev_timeout;
   logic ev_retry;
   logic [2:0] ev_err;
   logic [2:0] cap_clr;
   logic busy;

   // Reset release through two flops
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // Bus access qualifiers; a write takes effect when pready is sampled
   assign acc = psel & penable & r.pready;
   assign wr = acc & pwrite;
   // Busy covers the request and the wait for its answer
   assign busy = (r.st == dbe_pkg::DBE_SEND) || (r.st == dbe_pkg::DBE_WAIT);

   // Doorbell engine events, from the link response and the timeout counter
   always_comb begin
      ev_done = 1'b0;
      ev_err_rsp = 1'b0;
      ev_timeout = 1'b0;
      ev_retry = 1'b0;
      // The timeout counter restarts each time a request is taken
      if (r.st == dbe_pkg::DBE_WAIT) begin
         if (db_rsp_valid) begin
            ev_done = 1'b1;
            if (db_rsp_code == dbe_pkg::RSP_ERROR) begin
               ev_err_rsp = 1'b1;
            end else if (db_rsp_code == dbe_pkg::RSP_RETRY) begin
               // Retry beyond the limit ends the doorbell; otherwise it is resent
               ev_retry = (r.retries >= r.retry_limit);
               ev_done = ev_retry;
            end
         end else if (r.tmo == dbe_pkg::TMO_W'(dbe_pkg::RSP_TIMEOUT_CYC - 1)) begin
            ev_timeout = 1'b1;
            ev_done = 1'b1;
         end
      end
      ev_err = {ev_retry, ev_timeout, ev_err_rsp};
   end

   // Sticky flag sources and write-one clears
   always_comb begin
      st_set = {ev_retry, ev_timeout, ev_err_rsp, ev_done};
      st_clr = '0;
      pw_clr = 1'b0;
      irq_clr = '0;
      cap_clr = '0;
      // Written ones clear; written zeros leave a flag alone
      if (wr && paddr == dbe_pkg::STATUS_OFS) begin
         st_clr = pwdata[3:0];
      end
      if (wr && paddr == dbe_pkg::PORTWRITE_OFS) begin
         pw_clr = pwdata[0];
      end
      if (wr && paddr == dbe_pkg::IRQ_STATUS_OFS) begin
         irq_clr = pwdata[1:0];
      end
      if (wr && paddr == dbe_pkg::ERR_CAPTURE_OFS) begin
         cap_clr = pwdata[dbe_pkg::ERR_MSB:dbe_pkg::ERR_LSB];
      end
      // Every timeout also marks a pending port-write, whatever the enables
      pw_set = ev_timeout;
      irq_set = {|ev_err, ev_done};
   end

   // Doorbell status flags: done, error response, timeout, retry limit
   dbe_flag_bank #(.W(4)) u_status (
      .mclk(mclk),
      .rst_n(rst_n),
      .set(st_set),
      .clr(st_clr),
      .flags(st_flags)
   );

   // Port-write pending flag
   dbe_flag_bank #(.W(1)) u_portwrite (
      .mclk(mclk),
      .rst_n(rst_n),
      .set(pw_set),
      .clr(pw_clr),
      .flags(pw_flag)
   );

   // Interrupt status: done and any error, masked into irq
   dbe_flag_bank #(.W(2)) u_irq_status (
      .mclk(mclk),
      .rst_n(rst_n),
      .set(irq_set),
      .clr(irq_clr),
      .flags(irq_flags)
   );

   // Next state of registers, engine and bus answer
   always_comb begin
      logic [2:0] cap_left;
      logic [3:0] st_next;
      logic [1:0] irq_next;
      cap_left = '0;
      // Flag values after this edge, so interrupts follow their flags at once
      st_next = st_set | (st_flags & ~st_clr);
      irq_next = irq_set | (irq_flags & ~irq_clr);
      next_r = r;

      // Bus answer: one wait cycle, then pready for one cycle
      next_r.pready = psel & penable & ~r.pready;
      next_r.pslverr = 1'b0;
      next_r.prdata = '0;
      if (psel && penable && !r.pready) begin
         unique case (paddr)
            dbe_pkg::MODE_OFS: next_r.prdata[dbe_pkg::MODE_RUN_BIT] = r.run;
            dbe_pkg::ATTR_OFS: begin
               next_r.prdata[dbe_pkg::ATTR_IE_BIT] = r.attr_ie;
               next_r.prdata[dbe_pkg::ATTR_LIMIT_LSB +: 4] = r.retry_limit;
            end
            dbe_pkg::STATUS_OFS: begin
               next_r.prdata[3:0] = st_flags;
               next_r.prdata[dbe_pkg::ST_BUSY_BIT] = busy;
            end
            dbe_pkg::ERR_ENABLE_OFS: begin
               next_r.prdata[dbe_pkg::ERR_MSB:dbe_pkg::ERR_LSB] = r.err_en;
            end
            dbe_pkg::ERR_CAPTURE_OFS: begin
               next_r.prdata[dbe_pkg::ERR_MSB:dbe_pkg::ERR_LSB] = r.cap_bits;
               next_r.prdata[dbe_pkg::CAP_VALID_BIT] = r.cap_valid;
            end
            dbe_pkg::PORTWRITE_OFS: next_r.prdata[0] = pw_flag;
            dbe_pkg::IRQ_STATUS_OFS: next_r.prdata[1:0] = irq_flags;
            dbe_pkg::IRQ_MASK_OFS: next_r.prdata[1:0] = r.irq_mask;
            dbe_pkg::DQ_PTR_OFS: next_r.prdata = r.dq_ptr;
            dbe_pkg::DQ_PTR_UPPER_OFS: next_r.prdata = r.dq_ptr_upper;
            dbe_pkg::EQ_PTR_OFS: next_r.prdata = r.eq_ptr;
            dbe_pkg::EQ_PTR_UPPER_OFS: next_r.prdata = r.eq_ptr_upper;
            default: next_r.pslverr = 1'b1;
         endcase
      end

      // Software writes to plain registers
      if (wr) begin
         unique case (paddr)
            dbe_pkg::MODE_OFS: next_r.run = pwdata[dbe_pkg::MODE_RUN_BIT];
            dbe_pkg::ATTR_OFS: begin
               next_r.attr_ie = pwdata[dbe_pkg::ATTR_IE_BIT];
               next_r.retry_limit = pwdata[dbe_pkg::ATTR_LIMIT_LSB +: 4];
            end
            dbe_pkg::ERR_ENABLE_OFS: begin
               next_r.err_en = pwdata[dbe_pkg::ERR_MSB:dbe_pkg::ERR_LSB];
            end
            dbe_pkg::IRQ_MASK_OFS: next_r.irq_mask = pwdata[1:0];
            dbe_pkg::DQ_PTR_OFS: next_r.dq_ptr = pwdata;
            dbe_pkg::DQ_PTR_UPPER_OFS: next_r.dq_ptr_upper = pwdata;
            dbe_pkg::EQ_PTR_OFS: next_r.eq_ptr = pwdata;
            dbe_pkg::EQ_PTR_UPPER_OFS: next_r.eq_ptr_upper = pwdata;
            default: ;
         endcase
      end

      // Capture once: cleared bits by written ones, loaded only when empty
      cap_left = r.cap_bits & ~cap_clr;
      next_r.cap_bits = cap_left;
      next_r.cap_valid = |cap_left;
      // A clear that empties the capture and a new error in one cycle: the new error is kept
      if (|ev_err && !(|cap_left)) begin
         next_r.cap_bits = ev_err;
         next_r.cap_valid = 1'b1;
      end

      // Doorbell engine
      next_r.tx_valid = 1'b0;
      unique case (r.st)
         dbe_pkg::DBE_IDLE: begin
            next_r.retries = '0;
            // A start needs the run and send bits in one write
            if (wr && paddr == dbe_pkg::MODE_OFS && pwdata[dbe_pkg::MODE_RUN_BIT] &&
                pwdata[dbe_pkg::MODE_SEND_BIT]) begin
               next_r.st = dbe_pkg::DBE_SEND;
               next_r.tx_valid = 1'b1;
            end
         end
         dbe_pkg::DBE_SEND: begin
            next_r.tmo = '0;
            // Hold the request until the partner takes it
            next_r.tx_valid = ~db_tx_ready;
            if (db_tx_ready) begin
               next_r.st = dbe_pkg::DBE_WAIT;
            end
         end
         dbe_pkg::DBE_WAIT: begin
            next_r.tmo = r.tmo + 1'b1;
            // An error ends the doorbell and parks the engine
            if (|ev_err) begin
               next_r.st = dbe_pkg::DBE_HALT;
            end else if (ev_done) begin
               next_r.st = dbe_pkg::DBE_IDLE;
            end else if (db_rsp_valid) begin
               // Retry within the limit: resend
               next_r.retries = r.retries + 1'b1;
               next_r.st = dbe_pkg::DBE_SEND;
               next_r.tx_valid = 1'b1;
            end
         end
         dbe_pkg::DBE_HALT: begin
            // Stopped after an error until software clears the run bit
            if (!next_r.run) begin
               next_r.st = dbe_pkg::DBE_IDLE;
            end
         end
         default: next_r.st = dbe_pkg::DBE_IDLE;
      endcase

      // Interrupt outputs from next flag values
      // Enables and masks act in the cycle of their write
      next_r.db_irq = next_r.attr_ie & st_next[dbe_pkg::ST_DONE_BIT];
      next_r.err_irq = |(st_next[dbe_pkg::ERR_MSB:dbe_pkg::ERR_LSB] &
                         next_r.err_en);
      next_r.irq = |(irq_next & next_r.irq_mask);
   end

   // State register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '{st: dbe_pkg::DBE_IDLE, retry_limit: dbe_pkg::ATTR_LIMIT_RST, default: '0};
      end else begin
         r <= next_r;
      end
   end

   // Outputs straight from the state register
   assign pready = r.pready;
   assign prdata = r.prdata;
   assign pslverr = r.pslverr;
   assign db_tx_valid = r.tx_valid;
   assign db_irq = r.db_irq;
   assign err_irq = r.err_irq;
   assign irq = r.irq;

endmodule

`default_nettype wire

// [core/dbe_flag_bank.sv]
`timescale 1ns/1ps
`default_nettype none

module dbe_flag_bank #(
   parameter int W = 4
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [W-1:0] set,
   input wire logic [W-1:0] clr,
   output logic [W-1:0] flags
);

   logic [W-1:0] next_flags;

   // Per bit: a set in the same cycle as a clear wins; a zero written leaves the bit
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_comb begin
         next_flags[i] = set[i] | (flags[i] & ~clr[i]);
      end
   end

   // Flag storage
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         flags <= '0;
      end else begin
         flags <= next_flags;
      end
   end

endmodule

`default_nettype wire

// [include/dbe_pkg.sv]
package dbe_pkg;

   // Register byte offsets
   localparam logic [7:0] MODE_OFS = 8'h00;
   localparam logic [7:0] ATTR_OFS = 8'h04;
   localparam logic [7:0] STATUS_OFS = 8'h08;
   localparam logic [7:0] ERR_ENABLE_OFS = 8'h0c;
   localparam logic [7:0] ERR_CAPTURE_OFS = 8'h10;
   localparam logic [7:0] PORTWRITE_OFS = 8'h14;
   localparam logic [7:0] IRQ_STATUS_OFS = 8'h18;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h1c;
   localparam logic [7:0] DQ_PTR_OFS = 8'h20;
   localparam logic [7:0] DQ_PTR_UPPER_OFS = 8'h24;
   localparam logic [7:0] EQ_PTR_OFS = 8'h28;
   localparam logic [7:0] EQ_PTR_UPPER_OFS = 8'h2c;

   // Mode register fields
   localparam int MODE_RUN_BIT = 0;
   localparam int MODE_SEND_BIT = 1;
   // Attribute register fields
   localparam int ATTR_IE_BIT = 0;
   localparam int ATTR_LIMIT_LSB = 8;
   localparam logic [3:0] ATTR_LIMIT_RST = 4'h3;

   // Doorbell status layout; error-enable and capture share bits 1..3
   localparam int ST_DONE_BIT = 0;
   localparam int ST_ERR_RSP_BIT = 1;
   localparam int ST_TIMEOUT_BIT = 2;
   localparam int ST_RETRY_BIT = 3;
   localparam int ST_BUSY_BIT = 4;
   localparam int CAP_VALID_BIT = 31;
   localparam int ERR_LSB = 1;
   localparam int ERR_MSB = 3;

   // Interrupt status layout
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_ERR_BIT = 1;

   // Response codes from the link partner
   localparam logic [1:0] RSP_DONE = 2'h0;
   localparam logic [1:0] RSP_ERROR = 2'h1;
   localparam logic [1:0] RSP_RETRY = 2'h2;

   // Response timeout
   localparam int CLK_PERIOD_PS = 25000;
   localparam int RSP_TIMEOUT_NS = 10000;
   localparam int RSP_TIMEOUT_CYC = RSP_TIMEOUT_NS * 1000 / CLK_PERIOD_PS;
   localparam int TMO_W = 9;

   typedef enum logic [1:0] {
      DBE_IDLE = 2'h0,
      DBE_SEND = 2'h1,
      DBE_WAIT = 2'h3,
      DBE_HALT = 2'h2
   } dbe_state_t;

   typedef struct packed {
      dbe_state_t st;
      logic [TMO_W-1:0] tmo;
      logic [3:0] retries;
      logic run;
      logic attr_ie;
      logic [3:0] retry_limit;
      logic [2:0] err_en;
      logic cap_valid;
      logic [2:0] cap_bits;
      logic [1:0] irq_mask;
      logic [31:0] dq_ptr;
      logic [31:0] dq_ptr_upper;
      logic [31:0] eq_ptr;
      logic [31:0] eq_ptr_upper;
      logic tx_valid;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic err_irq;
      logic db_irq;
      logic irq;
   } dbe_regs_t;

endpackage
